// ==== core/usbcs_pkg.sv ====
package usbcs_pkg;
  // ------------------------------------------------------------
  // register word offsets (byte address = offset * 4)
  // ------------------------------------------------------------
  localparam logic [3:0] OFS_SYS_CTRL = 4'h0;
  localparam logic [3:0] OFS_PIN_STAT = 4'h1;
  localparam logic [3:0] OFS_EP_IRQ_EN = 4'h2;
  localparam logic [3:0] OFS_EP_EVENT = 4'h3;
  localparam logic [3:0] OFS_LINK_EVENT = 4'h4;
  localparam logic [3:0] OFS_SIZE_A = 4'h5;
  localparam logic [3:0] OFS_SIZE_B = 4'h6;
  localparam logic [3:0] OFS_SIZE_C = 4'h7;
  localparam logic [3:0] OFS_IN_CFG = 4'h8;
  localparam logic [3:0] OFS_OUT_CFG = 4'h9;
  localparam logic [3:0] OFS_FIFO_SEL = 4'ha;
  localparam logic [3:0] OFS_FIFO_DATA = 4'hb;
  localparam logic [3:0] OFS_FIFO_LEVEL = 4'hc;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_ENGINE_DISABLE = 6;
  localparam int BIT_PULLDOWN_OFF = 5;
  localparam int BIT_BUS_LEVEL = 4;
  localparam int BIT_ESD_FLAG = 0;
  localparam int BIT_OD_B_OUT = 7;
  localparam int BIT_OD_A_OUT = 6;
  localparam int BIT_OD_B_IN = 5;
  localparam int BIT_OD_A_IN = 4;
  localparam int BIT_SE1_NOISE = 3;
  localparam int BIT_SE0_NOISE = 2;
  localparam int BIT_LINE_RES = 1;
  localparam int BIT_EV_SUSPEND = 0;
  localparam int BIT_EV_RESUME = 1;
  localparam int BIT_EV_BUS_RESET = 2;
  // ------------------------------------------------------------
  // reset values and writable masks
  // ------------------------------------------------------------
  localparam logic [7:0] RST_SYS_CTRL = 8'h00;
  localparam logic [7:0] RST_PIN_STAT = 8'hc0;
  localparam logic [7:0] RST_EP_IRQ_EN = 8'h00;
  localparam logic [7:0] RST_SIZE = 8'h00;
  localparam logic [7:0] MASK_SIZE_A = 8'hfc;
  localparam logic [7:0] MASK_SIZE_C = 8'h05;
  localparam logic [7:0] MASK_OUT_CFG = 8'hf3;
  localparam int EP_COUNT = 8;
  localparam int EP_MAX_BYTES = 64;
  localparam int EP0_BYTES = 8;
endpackage

// ==== core/usbcs_ctrl.sv ====
`timescale 1ns/1ns
module usbcs_ctrl
  import usbcs_pkg::*;
#(
  parameter int FIFO_DEPTH = EP_MAX_BYTES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // serial engine side (same clock)
  input wire logic sie_rx_valid,
  input wire logic [2:0] sie_rx_ep,
  input wire logic [7:0] sie_rx_data,
  input wire logic sie_ep_access,
  input wire logic sie_esd_event,
  input wire logic sie_se1_event,
  input wire logic sie_se0_event,
  input wire logic sie_suspend_event,
  input wire logic sie_resume_event,
  input wire logic sie_bus_reset_event,
  // pins
  input wire logic bus_power_pin,
  input wire logic open_drain_a_in,
  input wire logic open_drain_b_in,
  output logic open_drain_a_out,
  output logic open_drain_a_oe,
  output logic open_drain_b_out,
  output logic open_drain_b_oe,
  output logic bus_power_pulldown_en,
  output logic line_resistor_enable,
  output logic engine_enable,
  output logic usb_irq
);
  // elaboration guard: every slot must hold the largest endpoint size
  if (FIFO_DEPTH < EP_MAX_BYTES || FIFO_DEPTH > 256) begin : g_bad_depth
    $error("fifo depth out of range");
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] pin_meta_ff;
  logic [2:0] pin_sync_ff;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta_ff <= 3'h0;
      pin_sync_ff <= 3'h0;
    end else begin
      pin_meta_ff <= {bus_power_pin, open_drain_b_in, open_drain_a_in};
      pin_sync_ff <= pin_meta_ff;
    end
  end
  logic bus_powered;
  assign bus_powered = pin_sync_ff[2];

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic engine_disable_ff;
  logic pulldown_off_ff;
  logic esd_flag_ff;
  logic [1:0] od_out_ff;
  logic se1_ff;
  logic se0_ff;
  logic pullup_ff;
  logic [7:0] irq_en_ff;
  logic [7:0] ep_flag_ff;
  logic [2:0] link_ev_ff;
  logic [7:0] size_a_ff;
  logic [7:0] size_b_ff;
  logic [7:0] size_c_ff;
  logic [7:0] in_cfg_ff;
  logic [7:0] out_cfg_ff;
  logic [2:0] fifo_sel_ff;
  logic [6:0] fifo_ptr_ff [EP_COUNT];
  logic [6:0] fifo_cnt_ff [EP_COUNT];
  logic [7:0] fifo_mem_ff [EP_COUNT][FIFO_DEPTH];
  logic ack_ff;
  logic [31:0] rdata_ff;

  // engine runs only when enabled and bus powered
  logic sie_live;
  assign sie_live = !engine_disable_ff && bus_powered;

  logic req;
  assign req = (avs_read || avs_write) && !ack_ff;
  logic wr_hit;
  // writes land on the edge where the master sees waitrequest low
  assign wr_hit = avs_write && ack_ff;
  logic [3:0] widx;
  assign widx = avs_address[5:2];
  logic [7:0] wd;
  assign wd = avs_writedata[7:0];

  function automatic logic sel(input logic [3:0] ofs);
    sel = wr_hit && (widx == ofs);
  endfunction

  // endpoint capacity in bytes: ep0 fixed, others from two size bits
  function automatic logic [6:0] ep_bytes(input int ep, input logic [7:0] sz_a, input logic [7:0] sz_b);
    logic [1:0] code;
    code = 2'h0;
    case (ep)
      1: code = sz_a[3:2];
      2: code = sz_a[5:4];
      3: code = sz_a[7:6];
      4: code = sz_b[1:0];
      5: code = sz_b[3:2];
      6: code = sz_b[5:4];
      7: code = sz_b[7:6];
      default: code = 2'h0;
    endcase
    if (ep == 0) begin
      ep_bytes = 7'(EP0_BYTES);
    end else begin
      ep_bytes = 7'(EP0_BYTES) << code;
    end
  endfunction

  // ------------------------------------------------------------
  // avalon handshake: one wait cycle on every access
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !req;
    end
  end

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      engine_disable_ff <= RST_SYS_CTRL[BIT_ENGINE_DISABLE];
      pulldown_off_ff <= RST_SYS_CTRL[BIT_PULLDOWN_OFF];
    end else if (sel(OFS_SYS_CTRL)) begin
      engine_disable_ff <= wd[BIT_ENGINE_DISABLE];
      pulldown_off_ff <= wd[BIT_PULLDOWN_OFF];
    end
  end

  // set wins over a same-cycle software clear; clear by writing 0
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      esd_flag_ff <= RST_SYS_CTRL[BIT_ESD_FLAG];
    end else if (sie_live && sie_esd_event) begin
      esd_flag_ff <= 1'b1;
    end else if (sel(OFS_SYS_CTRL) && !wd[BIT_ESD_FLAG]) begin
      esd_flag_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // pin status register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      od_out_ff <= RST_PIN_STAT[BIT_OD_B_OUT:BIT_OD_A_OUT];
      pullup_ff <= RST_PIN_STAT[BIT_LINE_RES];
    end else if (sel(OFS_PIN_STAT)) begin
      od_out_ff <= wd[BIT_OD_B_OUT:BIT_OD_A_OUT];
      pullup_ff <= wd[BIT_LINE_RES];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      se1_ff <= RST_PIN_STAT[BIT_SE1_NOISE];
      se0_ff <= RST_PIN_STAT[BIT_SE0_NOISE];
    end else begin
      if (sie_live && sie_se1_event) begin
        se1_ff <= 1'b1;
      end else if (sel(OFS_PIN_STAT) && !wd[BIT_SE1_NOISE]) begin
        se1_ff <= 1'b0;
      end
      if (sie_live && sie_se0_event) begin
        se0_ff <= 1'b1;
      end else if (sel(OFS_PIN_STAT) && !wd[BIT_SE0_NOISE]) begin
        se0_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt enables, endpoint flags, link events
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_en_ff <= RST_EP_IRQ_EN;
    end else if (sel(OFS_EP_IRQ_EN)) begin
      irq_en_ff <= wd;
    end
  end

  // write 0 to a flag bit clears it; a new access in that cycle wins
  logic [7:0] ep_set;
  assign ep_set = (sie_live && sie_ep_access) ? (8'h01 << sie_rx_ep) : 8'h00;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ep_flag_ff <= 8'h00;
    end else if (sel(OFS_EP_EVENT)) begin
      ep_flag_ff <= (ep_flag_ff & wd) | ep_set;
    end else begin
      ep_flag_ff <= ep_flag_ff | ep_set;
    end
  end

  logic [2:0] link_set;
  assign link_set = sie_live ? {sie_bus_reset_event, sie_resume_event, sie_suspend_event} : 3'h0;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      link_ev_ff <= 3'h0;
    end else if (sel(OFS_LINK_EVENT)) begin
      link_ev_ff <= (link_ev_ff & wd[2:0]) | link_set;
    end else begin
      link_ev_ff <= link_ev_ff | link_set;
    end
  end

  // ------------------------------------------------------------
  // fifo configuration
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      size_a_ff <= RST_SIZE;
      size_b_ff <= RST_SIZE;
      size_c_ff <= RST_SIZE;
      in_cfg_ff <= RST_SIZE;
      out_cfg_ff <= RST_SIZE;
      fifo_sel_ff <= 3'h0;
    end else begin
      if (sel(OFS_SIZE_A)) size_a_ff <= wd & MASK_SIZE_A;
      if (sel(OFS_SIZE_B)) size_b_ff <= wd;
      if (sel(OFS_SIZE_C)) size_c_ff <= wd & MASK_SIZE_C;
      if (sel(OFS_IN_CFG)) in_cfg_ff <= wd;
      if (sel(OFS_OUT_CFG)) out_cfg_ff <= wd & MASK_OUT_CFG;
      if (sel(OFS_FIFO_SEL)) fifo_sel_ff <= wd[2:0];
    end
  end

  // ------------------------------------------------------------
  // endpoint fifo storage: region sits in the top of a shared ram,
  // modelled here as per-endpoint slots; only the fill limit follows
  // the configured size, so no endpoint overruns its neighbour
  // ------------------------------------------------------------
  logic cpu_data_rd;
  assign cpu_data_rd = avs_read && !ack_ff && (widx == OFS_FIFO_DATA);
  genvar g;
  generate
    for (g = 0; g < EP_COUNT; g++) begin : g_ep
      logic rx_here;
      logic rd_here;
      assign rx_here = sie_live && sie_rx_valid && (sie_rx_ep == 3'(g))
                       && (fifo_cnt_ff[g] < ep_bytes(g, size_a_ff, size_b_ff));
      assign rd_here = cpu_data_rd && (fifo_sel_ff == 3'(g)) && (fifo_ptr_ff[g] != fifo_cnt_ff[g]);
      always_ff @(posedge core_clk) begin
        if (rx_here) begin
          fifo_mem_ff[g][fifo_cnt_ff[g][5:0]] <= sie_rx_data;
        end
      end
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          fifo_cnt_ff[g] <= 7'h00;
          fifo_ptr_ff[g] <= 7'h00;
        end else if (sel(OFS_FIFO_LEVEL) && wd[g]) begin
          fifo_cnt_ff[g] <= 7'h00;
          fifo_ptr_ff[g] <= 7'h00;
        end else begin
          if (rx_here) fifo_cnt_ff[g] <= fifo_cnt_ff[g] + 7'h01;
          if (rd_here) fifo_ptr_ff[g] <= fifo_ptr_ff[g] + 7'h01;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // read mux: unimplemented bits and offsets read zero
  // ------------------------------------------------------------
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (widx)
      OFS_SYS_CTRL: rd_byte = {1'b0, engine_disable_ff, pulldown_off_ff, bus_powered,
                               3'h0, esd_flag_ff};
      OFS_PIN_STAT: rd_byte = {od_out_ff, pin_sync_ff[1], pin_sync_ff[0], se1_ff, se0_ff,
                               pullup_ff, 1'b0};
      OFS_EP_IRQ_EN: rd_byte = irq_en_ff;
      OFS_EP_EVENT: rd_byte = ep_flag_ff;
      OFS_LINK_EVENT: rd_byte = {5'h00, link_ev_ff};
      OFS_SIZE_A: rd_byte = size_a_ff;
      OFS_SIZE_B: rd_byte = size_b_ff;
      OFS_SIZE_C: rd_byte = size_c_ff;
      OFS_IN_CFG: rd_byte = in_cfg_ff;
      OFS_OUT_CFG: rd_byte = out_cfg_ff;
      OFS_FIFO_SEL: rd_byte = {5'h00, fifo_sel_ff};
      OFS_FIFO_DATA: rd_byte = fifo_mem_ff[fifo_sel_ff][fifo_ptr_ff[fifo_sel_ff][5:0]];
      OFS_FIFO_LEVEL: rd_byte = {1'b0, fifo_cnt_ff[fifo_sel_ff]};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= 32'h0;
    end else if (avs_read && !ack_ff) begin
      rdata_ff <= {24'h0, rd_byte};
    end
  end
  assign avs_readdata = rdata_ff;

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      open_drain_a_out <= 1'b0;
      open_drain_b_out <= 1'b0;
      open_drain_a_oe <= 1'b0;
      open_drain_b_oe <= 1'b0;
      bus_power_pulldown_en <= 1'b1;
      line_resistor_enable <= 1'b0;
      engine_enable <= 1'b0;
      usb_irq <= 1'b0;
    end else begin
      open_drain_a_oe <= !od_out_ff[0];
      open_drain_b_oe <= !od_out_ff[1];
      bus_power_pulldown_en <= !pulldown_off_ff;
      line_resistor_enable <= pullup_ff;
      engine_enable <= sie_live;
      usb_irq <= |(ep_flag_ff & irq_en_ff) || |link_ev_ff;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_esd_set_sticky: assert property (@(posedge core_clk) disable iff (!nrst)
    (sie_live && sie_esd_event) |=> esd_flag_ff) else $error("esd flag not set");
  a_se1_set: assert property (@(posedge core_clk) disable iff (!nrst)
    (sie_live && sie_se1_event) |=> se1_ff) else $error("se1 flag not set");
  a_se0_set: assert property (@(posedge core_clk) disable iff (!nrst)
    (sie_live && sie_se0_event) |=> se0_ff) else $error("se0 flag not set");
  a_ep_flag_set: assert property (@(posedge core_clk) disable iff (!nrst)
    (sie_live && sie_ep_access) |=> ep_flag_ff[$past(sie_rx_ep)]) else $error("endpoint flag lost");
  a_irq_gating: assert property (@(posedge core_clk) disable iff (!nrst)
    ##1 usb_irq == ($past(|(ep_flag_ff & irq_en_ff)) || $past(|link_ev_ff))) else $error("irq mismatch");
  a_engine_power: assert property (@(posedge core_clk) disable iff (!nrst)
    !bus_powered |=> !engine_enable) else $error("engine live without power");
  a_disable_blocks: assert property (@(posedge core_clk) disable iff (!nrst)
    engine_disable_ff |-> !(link_set != 3'h0 || ep_set != 8'h00)) else $error("disabled engine acted");
  a_od_drive: assert property (@(posedge core_clk) disable iff (!nrst)
    sel(OFS_PIN_STAT) |-> ##2 open_drain_a_oe == !$past(wd[BIT_OD_A_OUT], 2)) else $error("open drain wrong");
  a_fifo_bound: assert property (@(posedge core_clk) disable iff (!nrst)
    fifo_cnt_ff[0] <= 7'(EP0_BYTES)) else $error("ep0 overfilled");
  a_bus_answer: assert property (@(posedge core_clk) disable iff (!nrst)
    ((avs_read || avs_write) && avs_waitrequest && !ack_ff) |=> !avs_waitrequest) else $error("no answer");
endmodule

// ==== verif/usbcs_host_model.sv ====
`timescale 1ns/1ns
module usbcs_host_model (
  // clock
  input wire logic core_clk,
  // engine side
  output logic sie_rx_valid,
  output logic [2:0] sie_rx_ep,
  output logic [7:0] sie_rx_data,
  output logic sie_ep_access,
  output logic sie_esd_event,
  output logic sie_se1_event,
  output logic sie_se0_event,
  output logic sie_suspend_event,
  output logic sie_resume_event,
  output logic sie_bus_reset_event
);
  logic [5:0] ev = 6'h00;
  assign {sie_bus_reset_event, sie_resume_event, sie_suspend_event} = ev[5:3];
  assign {sie_se0_event, sie_se1_event, sie_esd_event} = ev[2:0];
  initial begin
    sie_rx_valid = 1'b0;
    sie_rx_ep = 3'h0;
    sie_rx_data = 8'h00;
    sie_ep_access = 1'b0;
  end
  // data byte is invalid outside its pulse, so it is scrambled rather than held
  task automatic rx(input logic [2:0] ep, input logic [7:0] d);
    sie_rx_ep <= ep;
    sie_rx_data <= d;
    sie_rx_valid <= 1'b1;
    @(posedge core_clk);
    sie_rx_valid <= 1'b0;
    sie_rx_data <= ~d;
    @(posedge core_clk);
  endtask
  task automatic access(input logic [2:0] ep);
    sie_rx_ep <= ep;
    sie_ep_access <= 1'b1;
    @(posedge core_clk);
    sie_ep_access <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic pulse(input int k);
    ev <= 6'h01 << k;
    @(posedge core_clk);
    ev <= 6'h00;
    @(posedge core_clk);
  endtask
endmodule

// ==== verif/usb_device_control_status_tb.sv ====
`timescale 1ns/1ns
module usb_device_control_status_tb
  import usbcs_pkg::*;
;
  logic core_clk, nrst, avs_read, avs_write, avs_waitrequest;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdv;
  logic sie_rx_valid, sie_ep_access, sie_esd_event, sie_se1_event, sie_se0_event;
  logic sie_suspend_event, sie_resume_event, sie_bus_reset_event;
  logic [2:0] sie_rx_ep;
  logic [7:0] sie_rx_data;
  logic bus_power_pin, ext_a_low, ext_b_low, od_a, od_b, a_out, a_oe, b_out, b_oe;
  logic pd_en, line_res, eng_en, usb_irq;
  logic [3:0] cfg_ofs [5] = '{OFS_SIZE_A, OFS_SIZE_B, OFS_SIZE_C, OFS_IN_CFG, OFS_OUT_CFG};
  logic [7:0] cfg_msk [5] = '{MASK_SIZE_A, 8'hff, MASK_SIZE_C, 8'hff, MASK_OUT_CFG};
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  // open-drain lines are pulled high when nobody sinks them
  assign od_a = (a_oe ? a_out : 1'b1) & ~ext_a_low;
  assign od_b = (b_oe ? b_out : 1'b1) & ~ext_b_low;
  usbcs_ctrl #(.FIFO_DEPTH(64)) u_usbcs_ctrl (
    .core_clk(core_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sie_rx_valid(sie_rx_valid), .sie_rx_ep(sie_rx_ep),
    .sie_rx_data(sie_rx_data), .sie_ep_access(sie_ep_access), .sie_esd_event(sie_esd_event),
    .sie_se1_event(sie_se1_event), .sie_se0_event(sie_se0_event), .sie_suspend_event(sie_suspend_event),
    .sie_resume_event(sie_resume_event), .sie_bus_reset_event(sie_bus_reset_event),
    .bus_power_pin(bus_power_pin), .open_drain_a_in(od_a), .open_drain_b_in(od_b),
    .open_drain_a_out(a_out), .open_drain_a_oe(a_oe), .open_drain_b_out(b_out), .open_drain_b_oe(b_oe),
    .bus_power_pulldown_en(pd_en), .line_resistor_enable(line_res), .engine_enable(eng_en), .usb_irq(usb_irq));
  usbcs_host_model u_usbcs_host_model (
    .core_clk(core_clk), .sie_rx_valid(sie_rx_valid), .sie_rx_ep(sie_rx_ep), .sie_rx_data(sie_rx_data),
    .sie_ep_access(sie_ep_access), .sie_esd_event(sie_esd_event), .sie_se1_event(sie_se1_event),
    .sie_se0_event(sie_se0_event), .sie_suspend_event(sie_suspend_event),
    .sie_resume_event(sie_resume_event), .sie_bus_reset_event(sie_bus_reset_event));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // hang guard
  // ------------------------------------------------------------
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      $display("mismatch at %0t: run timed out", $time);
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // ------------------------------------------------------------
  // avalon-mm master: hold until waitrequest low, then release
  // ------------------------------------------------------------
  task automatic bus(input logic wr, input logic [3:0] ofs, input logic [7:0] wd);
    avs_address <= {ofs, 2'b00};
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, wd};
    // no cap of its own: a dead bus is ended by the hang guard
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [3:0] ofs, input logic [7:0] d);
    bus(1'b1, ofs, d);
  endtask
  task automatic rd_chk(input logic [3:0] ofs, input logic [7:0] exp, input string what);
    bus(1'b0, ofs, 8'h00);
    chk(rdv, {24'h0, exp}, what);
  endtask
  task automatic done(input string name);
    $display("test %s done, checks %0d", name, n_checks);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    bus_power_pin = 1'b0;
    ext_a_low = 1'b0;
    ext_b_low = 1'b0;
    tick(6);
    nrst <= 1'b1;
    tick(1);
    rd_chk(OFS_SYS_CTRL, RST_SYS_CTRL, "sys reset");
    rd_chk(OFS_PIN_STAT, 8'hf0, "pin reset");
    rd_chk(OFS_EP_IRQ_EN, RST_EP_IRQ_EN, "irq en reset");
    chk({a_oe, b_oe, pd_en, line_res, eng_en, usb_irq}, 32'h8, "reset pins");
    done("reset");
    for (int o = 13; o < 16; o++) begin
      wr(o[3:0], 8'hff);
      rd_chk(o[3:0], 8'h00, "unmapped");
    end
    wr(OFS_SYS_CTRL, 8'hfd);
    rd_chk(OFS_SYS_CTRL, 8'h60, "sys rw mask");
    chk({pd_en, eng_en}, 32'h0, "pulldown off");
    wr(OFS_PIN_STAT, 8'hff);
    rd_chk(OFS_PIN_STAT, 8'hf2, "pin rw mask");
    chk(line_res, 1, "pullups on");
    wr(OFS_EP_IRQ_EN, 8'ha5);
    rd_chk(OFS_EP_IRQ_EN, 8'ha5, "irq en rw");
    for (int i = 0; i < 5; i++) begin
      wr(cfg_ofs[i], 8'hff);
      rd_chk(cfg_ofs[i], cfg_msk[i], "cfg mask");
      wr(cfg_ofs[i], 8'h00);
    end
    done("access");
    bus_power_pin <= 1'b1;
    wr(OFS_SYS_CTRL, 8'h00);
    tick(5);
    chk({pd_en, eng_en}, 32'h3, "engine live");
    rd_chk(OFS_SYS_CTRL, 8'h10, "bus level");
    wr(OFS_PIN_STAT, 8'h80);
    ext_b_low <= 1'b1;
    tick(4);
    chk({a_oe, a_out, b_oe}, 32'h4, "drain a sinks");
    rd_chk(OFS_PIN_STAT, 8'h80, "drain inputs");
    ext_b_low <= 1'b0;
    done("pins");
    for (int k = 0; k < 3; k++) u_usbcs_host_model.pulse(k);
    rd_chk(OFS_SYS_CTRL, 8'h11, "esd set");
    rd_chk(OFS_PIN_STAT, 8'hac, "noise set");
    wr(OFS_SYS_CTRL, 8'h01);
    wr(OFS_PIN_STAT, 8'hc8);
    rd_chk(OFS_SYS_CTRL, 8'h11, "esd write one keeps");
    rd_chk(OFS_PIN_STAT, 8'hf8, "se0 cleared");
    wr(OFS_SYS_CTRL, 8'h00);
    wr(OFS_PIN_STAT, 8'hc0);
    rd_chk(OFS_SYS_CTRL, 8'h10, "esd cleared");
    wr(OFS_SYS_CTRL, 8'h40);
    u_usbcs_host_model.pulse(0);
    rd_chk(OFS_SYS_CTRL, 8'h50, "disabled ignores");
    wr(OFS_SYS_CTRL, 8'h00);
    done("flags");
    for (int e = 0; e < 8; e++) begin
      u_usbcs_host_model.access(e[2:0]);
      tick(1);
      chk(usb_irq, 32'((8'ha5 >> e) & 8'h01), "ep irq gate");
      rd_chk(OFS_EP_EVENT, 8'h01 << e, "ep flag");
      wr(OFS_EP_EVENT, 8'h00);
      tick(2);
      chk(usb_irq, 0, "ep irq clear");
    end
    for (int k = 3; k < 6; k++) begin
      u_usbcs_host_model.pulse(k);
      tick(1);
      chk(usb_irq, 1, "link irq");
      rd_chk(OFS_LINK_EVENT, 8'h01 << (k - 3), "link flag");
      wr(OFS_LINK_EVENT, 8'h00);
      tick(2);
      chk(usb_irq, 0, "link irq clear");
    end
    done("interrupts");
    wr(OFS_FIFO_LEVEL, 8'hff);
    wr(OFS_FIFO_SEL, 8'h00);
    for (int i = 0; i < 9; i++) u_usbcs_host_model.rx(3'h0, 8'h30 + i[7:0]);
    rd_chk(OFS_FIFO_LEVEL, 8'h08, "ep0 level capped");
    for (int i = 0; i < 8; i++) rd_chk(OFS_FIFO_DATA, 8'h30 + i[7:0], "ep0 fifo byte");
    wr(OFS_SIZE_A, 8'h04);
    wr(OFS_FIFO_SEL, 8'h01);
    for (int i = 0; i < 17; i++) u_usbcs_host_model.rx(3'h1, i[7:0]);
    rd_chk(OFS_FIFO_LEVEL, 8'h10, "ep1 16 byte level");
    rd_chk(OFS_FIFO_DATA, 8'h00, "ep1 first byte");
    wr(OFS_SIZE_B, 8'hc0);
    wr(OFS_FIFO_SEL, 8'h07);
    for (int i = 0; i < 65; i++) u_usbcs_host_model.rx(3'h7, 8'h80 + i[7:0]);
    rd_chk(OFS_FIFO_LEVEL, 8'h40, "ep7 64 byte level");
    for (int i = 0; i < 64; i++) rd_chk(OFS_FIFO_DATA, 8'h80 + i[7:0], "ep7 fifo byte");
    done("fifo");
    bus_power_pin <= 1'b0;
    tick(5);
    chk(eng_en, 0, "unpowered engine off");
    u_usbcs_host_model.pulse(0);
    rd_chk(OFS_SYS_CTRL, 8'h00, "unpowered ignores");
    done("power");
    summarize();
  end
endmodule
